// ==== rtl/hmb_pkg.sv ====
// Constants shared by the host miscellaneous and buffer length register bank
//Contract
//R1 - Command 27h reads product code and revision
//R2 - Scratch word: write A8h, read 28h, zero reset
//R3 - Writing F6h via A9h resets host registers
//R4 - Soft reset leaves buffer memory contents alone
//R5 - Periodic length: write AAh, read 2Ah, zero reset
//R6 - Both periodic areas take the same length
//R7 - Async plus twice periodic within 1000h bytes
//R8 - Async length: write ABh, read 2Bh
//R9 - Other values to A9h change nothing
package hmb_pkg;

  localparam int unsigned HMB_DATA_W = 16;
  localparam int unsigned HMB_CODE_W = 8;
  localparam int unsigned HMB_SUM_W  = 18;

  // Read command codes
  localparam logic [7:0] HMB_RD_IDENTITY = 8'h27;
  localparam logic [7:0] HMB_RD_SCRATCH  = 8'h28;
  localparam logic [7:0] HMB_RD_PERIODIC = 8'h2a;
  localparam logic [7:0] HMB_RD_ASYNC    = 8'h2b;

  // Write command codes
  localparam logic [7:0] HMB_WR_SCRATCH  = 8'ha8;
  localparam logic [7:0] HMB_WR_SOFT_RST = 8'ha9;
  localparam logic [7:0] HMB_WR_PERIODIC = 8'haa;
  localparam logic [7:0] HMB_WR_ASYNC    = 8'hab;

  // Bit that marks a write command
  localparam int unsigned HMB_WRITE_BIT = 7;

  // Value that triggers a soft reset
  localparam logic [15:0] HMB_SOFT_RST_KEY = 16'h00f6;

  // Reset values and the unmapped read value
  localparam logic [15:0] HMB_SCRATCH_RST  = 16'h0000;
  localparam logic [15:0] HMB_PERIODIC_RST = 16'h0000;
  localparam logic [15:0] HMB_ASYNC_RST    = 16'h0000;
  localparam logic [15:0] HMB_RDATA_RST    = 16'h0000;
  localparam logic [15:0] HMB_UNMAPPED_VAL = 16'h0000;

  // Total buffer memory in bytes
  localparam logic [17:0] HMB_BUFFER_BYTES = 18'h01000;

  // Decoded command kinds
  typedef enum logic [2:0] {
    HMB_CMD_NONE     = 3'b000,
    HMB_CMD_IDENTITY = 3'b001,
    HMB_CMD_SCRATCH  = 3'b010,
    HMB_CMD_SOFT_RST = 3'b011,
    HMB_CMD_PERIODIC = 3'b100,
    HMB_CMD_ASYNC    = 3'b101
  } hmb_cmd_t;

endpackage : hmb_pkg

// ==== rtl/hmb_buffer_map.sv ====
// Buffer memory area map derived from the programmed lengths
`timescale 1ns/1ns
`default_nettype none

module hmb_buffer_map
  import hmb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] periodicLen,
  input  wire logic [15:0] asyncLen,
  output logic      [15:0] periodic0Base,
  output logic      [15:0] periodic1Base,
  output logic      [15:0] asyncBase,
  output logic      [17:0] bufferBytesUsed,
  output logic             lengthOverflow
);

  logic [17:0] next_periodic1;
  logic [17:0] next_async;
  logic [17:0] next_used;

  // Periodic area 1 follows area 0, async area follows both
  always_comb begin
    next_periodic1 = {2'b00, periodicLen};                 // R6
    next_async     = next_periodic1 + {2'b00, periodicLen}; // R6
    next_used      = next_async + {2'b00, asyncLen};
  end

  // Registered area bases and usage
  always_ff @(posedge clk) begin
    if (rst) begin
      periodic0Base   <= 16'h0000;
      periodic1Base   <= 16'h0000;
      asyncBase       <= 16'h0000;
      bufferBytesUsed <= 18'h00000;
    end else begin
      periodic0Base   <= 16'h0000;
      periodic1Base   <= next_periodic1[15:0];
      asyncBase       <= next_async[15:0];
      bufferBytesUsed <= next_used;
    end
  end

  // Flag a programming that does not fit the buffer memory
  always_ff @(posedge clk) begin
    if (rst) begin
      lengthOverflow <= 1'b0;
    end else begin
      lengthOverflow <= (next_used > HMB_BUFFER_BYTES); // R7
    end
  end

endmodule : hmb_buffer_map

`default_nettype wire

// ==== rtl/hmb_misc_regs.sv ====
// Host miscellaneous and buffer length register bank behind the command port
`timescale 1ns/1ns
`default_nettype none

module hmb_misc_regs
  import hmb_pkg::*;
#(
  // Arbitrary neutral identity values
  parameter logic [7:0] PRODUCT_CODE  = 8'h5a,
  parameter logic [7:0] REVISION_CODE = 8'h01
)
(
  // Clock and synchronous reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Command port from the microprocessor
  input  wire logic        cmdStrobe,
  input  wire logic [7:0]  cmdCode,
  input  wire logic [15:0] cmdWrData,
  // Read answer and status pulses
  output logic      [15:0] rdData,
  output logic             rdValid,
  output logic             cmdUnknown,
  output logic             hostSoftReset,
  // Programmed lengths and buffer area map
  output logic      [15:0] periodicBufferLength,
  output logic      [15:0] asyncBufferLength,
  output logic      [15:0] periodic0Base,
  output logic      [15:0] periodic1Base,
  output logic      [15:0] asyncBase,
  output logic      [17:0] bufferBytesUsed,
  output logic             lengthOverflow
);

  // Command decode and strobes
  hmb_cmd_t    cmdKind;
  logic        isWrite;
  logic        wrStrobe;
  logic        rdStrobe;
  logic        wrScratch;
  logic        wrPeriodic;
  logic        wrAsync;
  logic        softResetHit;
  logic        regReset;

  // Register storage and read path
  logic [15:0] softwareScratchWord;
  logic [15:0] partIdentityWord;
  logic [15:0] next_rdData;
  logic        next_unknown;

  // Identity word: product code high, revision low
  assign partIdentityWord = {PRODUCT_CODE, REVISION_CODE}; // R1

  // Split the command into direction and strobe
  assign isWrite  = cmdCode[HMB_WRITE_BIT];
  assign wrStrobe = cmdStrobe & isWrite;
  assign rdStrobe = cmdStrobe & ~isWrite;

  // Decode the command code against both directions
  always_comb begin
    cmdKind = HMB_CMD_NONE;
    case (cmdCode)
      HMB_RD_IDENTITY: begin
        cmdKind = HMB_CMD_IDENTITY;
      end
      HMB_RD_SCRATCH, HMB_WR_SCRATCH: begin
        cmdKind = HMB_CMD_SCRATCH;
      end
      HMB_WR_SOFT_RST: begin
        cmdKind = HMB_CMD_SOFT_RST;
      end
      HMB_RD_PERIODIC, HMB_WR_PERIODIC: begin
        cmdKind = HMB_CMD_PERIODIC;
      end
      HMB_RD_ASYNC, HMB_WR_ASYNC: begin
        cmdKind = HMB_CMD_ASYNC;
      end
      default: begin
        cmdKind = HMB_CMD_NONE;
      end
    endcase
  end

  // Per-register write enables; reads and unserved codes enable nothing
  always_comb begin
    wrScratch  = 1'b0;
    wrPeriodic = 1'b0;
    wrAsync    = 1'b0;
    if (wrStrobe) begin
      case (cmdKind)
        HMB_CMD_SCRATCH: begin
          wrScratch = 1'b1; // R2
        end
        HMB_CMD_PERIODIC: begin
          wrPeriodic = 1'b1; // R5
        end
        HMB_CMD_ASYNC: begin
          wrAsync = 1'b1; // R8
        end
        default: begin
          wrScratch = 1'b0;
        end
      endcase
    end
  end

  // Soft reset fires only on the key value, others are ignored
  assign softResetHit = wrStrobe
                        && (cmdKind == HMB_CMD_SOFT_RST)
                        && (cmdWrData == HMB_SOFT_RST_KEY); // R3 R9

  // Registers return to reset on hardware or soft reset
  assign regReset = rst | softResetHit; // R3

  // Soft reset pulse to the rest of the host side; buffer memory is not wired to it
  always_ff @(posedge clk) begin
    if (rst) begin
      hostSoftReset <= 1'b0;
    end else begin
      hostSoftReset <= softResetHit; // R3 R4
    end
  end

  // Scratch word storage
  always_ff @(posedge clk) begin
    if (regReset) begin
      softwareScratchWord <= HMB_SCRATCH_RST; // R2
    end else if (wrScratch) begin
      softwareScratchWord <= cmdWrData; // R2
    end
  end

  // Periodic list buffer length, shared by both periodic areas
  always_ff @(posedge clk) begin
    if (regReset) begin
      periodicBufferLength <= HMB_PERIODIC_RST; // R5
    end else if (wrPeriodic) begin
      periodicBufferLength <= cmdWrData; // R5
    end
  end

  // Async list buffer length
  always_ff @(posedge clk) begin
    if (regReset) begin
      asyncBufferLength <= HMB_ASYNC_RST;
    end else if (wrAsync) begin
      asyncBufferLength <= cmdWrData; // R8
    end
  end

  // Read data selection; write-only and unmapped codes read as zero
  always_comb begin
    next_rdData  = HMB_UNMAPPED_VAL;
    next_unknown = 1'b0;
    case (cmdKind)
      HMB_CMD_IDENTITY: begin
        next_rdData = partIdentityWord; // R1
      end
      HMB_CMD_SCRATCH: begin
        next_rdData = softwareScratchWord; // R2
      end
      HMB_CMD_PERIODIC: begin
        next_rdData = periodicBufferLength; // R5
      end
      HMB_CMD_ASYNC: begin
        next_rdData = asyncBufferLength; // R8
      end
      HMB_CMD_SOFT_RST: begin
        next_rdData  = HMB_UNMAPPED_VAL;
        next_unknown = ~isWrite;
      end
      HMB_CMD_NONE: begin
        next_rdData  = HMB_UNMAPPED_VAL;
        next_unknown = 1'b1;
      end
      default: begin
        next_rdData  = HMB_UNMAPPED_VAL;
        next_unknown = 1'b1;
      end
    endcase
  end

  // Read answer valid one cycle after the read strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdValid <= 1'b0;
    end else begin
      rdValid <= rdStrobe;
    end
  end

  // Read data register, held until the next read
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData <= HMB_RDATA_RST;
    end else if (rdStrobe) begin
      rdData <= next_rdData;
    end
  end

  // Pulse for any command code this bank does not serve
  always_ff @(posedge clk) begin
    if (rst) begin
      cmdUnknown <= 1'b0;
    end else begin
      cmdUnknown <= cmdStrobe & next_unknown;
    end
  end

  // Area map of the buffer memory from the two lengths
  hmb_buffer_map uMap (
    .clk             (clk),
    .rst             (rst),
    .periodicLen     (periodicBufferLength),
    .asyncLen        (asyncBufferLength),
    .periodic0Base   (periodic0Base),
    .periodic1Base   (periodic1Base),
    .asyncBase       (asyncBase),
    .bufferBytesUsed (bufferBytesUsed),
    .lengthOverflow  (lengthOverflow)
  );

endmodule : hmb_misc_regs

`default_nettype wire

// ==== testbench/hmb_host_cpu.sv ====
// Microprocessor model driving the command port
`timescale 1ns/1ns
`default_nettype none
module hmb_host_cpu (
  input  wire logic        clk,
  output logic             cmdStrobe,
  output logic      [7:0]  cmdCode,
  output logic      [15:0] cmdWrData
);
  initial begin
    cmdStrobe = 1'b0;
    cmdCode = 8'h00;
    cmdWrData = 16'h0000;
  end
  // Called at a falling edge; holds the request over one rising edge
  task automatic issue(input logic [7:0] code, input logic [15:0] data);
    cmdStrobe = 1'b1;
    cmdCode = code;
    cmdWrData = data;
    @(negedge clk);
  endtask : issue
  // Released lines show the inverse of the last value
  task automatic idle();
    cmdStrobe = 1'b0;
    cmdCode = ~cmdCode;
    cmdWrData = ~cmdWrData;
  endtask : idle
endmodule : hmb_host_cpu
`default_nettype wire

// ==== testbench/hmb_misc_regs_checker.sv ====
// Concurrent checks on the register bank ports
`timescale 1ns/1ns
`default_nettype none
module hmb_misc_regs_checker
  import hmb_pkg::*;
#(
  parameter logic [7:0] PRODUCT_CODE  = 8'h5a,
  parameter logic [7:0] REVISION_CODE = 8'h01
)
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cmdStrobe,
  input wire logic [7:0]  cmdCode,
  input wire logic [15:0] cmdWrData,
  input wire logic [15:0] rdData,
  input wire logic        rdValid,
  input wire logic        hostSoftReset,
  input wire logic [15:0] periodicBufferLength,
  input wire logic [15:0] asyncBufferLength,
  input wire logic [15:0] periodic0Base,
  input wire logic [15:0] periodic1Base,
  input wire logic [15:0] asyncBase
);
  // Decoded requests
  wire logic wrScr  = cmdStrobe && (cmdCode == HMB_WR_SCRATCH);
  wire logic rdScr  = cmdStrobe && (cmdCode == HMB_RD_SCRATCH);
  wire logic softWr = cmdStrobe && (cmdCode == HMB_WR_SOFT_RST);
  wire logic keyOk  = cmdWrData == HMB_SOFT_RST_KEY;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_ID_READ: assert property (cmdStrobe && cmdCode == HMB_RD_IDENTITY
    |=> rdValid && rdData == {PRODUCT_CODE, REVISION_CODE}) else $error("identity read wrong");
  AST_SCRATCH_LOOP: assert property (rdScr && $past(wrScr)
    |=> rdValid && rdData == $past(cmdWrData, 2)) else $error("scratch readback wrong");
  AST_SOFT_RST: assert property (softWr && keyOk
    |=> hostSoftReset && periodicBufferLength == 16'h0000 && asyncBufferLength == 16'h0000)
    else $error("soft reset missed");
  AST_RST_CAUSE: assert property (hostSoftReset |-> $past(softWr) && $past(keyOk))
    else $error("soft reset without key");
  AST_BAD_KEY: assert property (softWr && !keyOk
    |=> !hostSoftReset && $stable(periodicBufferLength) && $stable(asyncBufferLength))
    else $error("wrong key changed state");
  AST_PERIODIC_WR: assert property (cmdStrobe && cmdCode == HMB_WR_PERIODIC
    |=> periodicBufferLength == $past(cmdWrData)) else $error("periodic length not written");
  AST_ASYNC_WR: assert property (cmdStrobe && cmdCode == HMB_WR_ASYNC
    |=> asyncBufferLength == $past(cmdWrData)) else $error("async length not written");
  AST_AREA_MAP: assert property (!$past(rst) |-> periodic0Base == 16'h0000
    && periodic1Base == $past(periodicBufferLength) && asyncBase == ($past(periodicBufferLength) << 1))
    else $error("area map wrong");
  // Main scenarios
  cover property (softWr && keyOk);
  cover property (softWr && !keyOk);
  cover property (rdScr && $past(wrScr));
endmodule : hmb_misc_regs_checker
bind hmb_misc_regs hmb_misc_regs_checker #(.PRODUCT_CODE(PRODUCT_CODE), .REVISION_CODE(REVISION_CODE))
  hmb_misc_regs_checker_i (.clk(clk), .rst(rst), .cmdStrobe(cmdStrobe), .cmdCode(cmdCode),
  .cmdWrData(cmdWrData), .rdData(rdData), .rdValid(rdValid), .hostSoftReset(hostSoftReset),
  .periodicBufferLength(periodicBufferLength), .asyncBufferLength(asyncBufferLength),
  .periodic0Base(periodic0Base), .periodic1Base(periodic1Base), .asyncBase(asyncBase));
`default_nettype wire

// ==== testbench/host_misc_and_buffer_config_regs_test.sv ====
// Self-checking bench for the register bank
`timescale 1ns/1ns
`default_nettype none
module host_misc_and_buffer_config_regs_test
  import hmb_pkg::*;
;
  localparam logic [7:0] ID_PROD = 8'h3c; // Arbitrary identity value
  localparam logic [7:0] ID_REV  = 8'h07; // Arbitrary identity value
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cmdStrobe, rdValid, cmdUnknown, hostSoftReset, lengthOverflow;
  logic [7:0]  cmdCode;
  logic [15:0] cmdWrData, rdData, periodicBufferLength, asyncBufferLength;
  logic [15:0] periodic0Base, periodic1Base, asyncBase;
  logic [17:0] bufferBytesUsed;
  logic [15:0] expQ[$];
  logic [16:0] lfsr = 17'h1249f;
  int          miscompares = 0;
  int          check_count = 0;
  hmb_host_cpu hmb_host_cpu_i (.clk(clk), .cmdStrobe(cmdStrobe), .cmdCode(cmdCode), .cmdWrData(cmdWrData));
  hmb_misc_regs #(.PRODUCT_CODE(ID_PROD), .REVISION_CODE(ID_REV)) hmb_misc_regs_i (.clk(clk), .rst(rst),
    .cmdStrobe(cmdStrobe), .cmdCode(cmdCode), .cmdWrData(cmdWrData), .rdData(rdData), .rdValid(rdValid),
    .cmdUnknown(cmdUnknown), .hostSoftReset(hostSoftReset), .periodicBufferLength(periodicBufferLength),
    .asyncBufferLength(asyncBufferLength), .periodic0Base(periodic0Base), .periodic1Base(periodic1Base),
    .asyncBase(asyncBase), .bufferBytesUsed(bufferBytesUsed), .lengthOverflow(lengthOverflow));
  initial begin
    forever #50 clk = ~clk;
  end
  function automatic logic [16:0] lfsr_next(input logic [16:0] x);
    return {x[15:0], x[16] ^ x[13]};
  endfunction : lfsr_next
  task automatic check_word(input string what, input logic [17:0] exp, input logic [17:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  // Read notes its expected answer, write just issues
  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    expQ.push_back(exp);
    hmb_host_cpu_i.issue(code, ~exp);
  endtask : rd
  // Each read answer is matched against the oldest note
  always @(negedge clk) begin
    if (rdValid === 1'b1) begin
      if (expQ.size() == 0) begin
        check_word("rdValid without read", 18'h00000, 18'h00001);
      end else begin
        check_word("rdData", {2'b00, expQ.pop_front()}, {2'b00, rdData});
      end
    end
  end
  // About 31 cycles of traffic, so 300 cycles means a hang
  initial begin
    #30000;
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rd(HMB_RD_IDENTITY, {ID_PROD, ID_REV});
    check_word("cmdUnknown", 18'h00000, {17'h00000, cmdUnknown});
    rd(HMB_RD_SCRATCH, 16'h0000);
    rd(HMB_RD_PERIODIC, 16'h0000);
    rd(8'h2c, 16'h0000); // Unmapped code reads zero
    check_word("cmdUnknown", 18'h00001, {17'h00000, cmdUnknown});
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      hmb_host_cpu_i.issue(HMB_WR_SCRATCH, lfsr[15:0]);
      rd(HMB_RD_SCRATCH, lfsr[15:0]);
    end
    hmb_host_cpu_i.issue(HMB_WR_PERIODIC, 16'h0400);
    hmb_host_cpu_i.issue(HMB_WR_ASYNC, 16'h0800);
    rd(HMB_RD_PERIODIC, 16'h0400);
    rd(HMB_RD_ASYNC, 16'h0800);
    check_word("periodic1Base", 18'h00400, {2'b00, periodic1Base});
    check_word("asyncBase", 18'h00800, {2'b00, asyncBase});
    check_word("bufferBytesUsed", 18'h01000, bufferBytesUsed);
    check_word("periodic0Base", 18'h00000, {2'b00, periodic0Base});
    check_word("lengthOverflow", 18'h00000, {17'h00000, lengthOverflow});
    hmb_host_cpu_i.issue(HMB_WR_ASYNC, 16'h0801);
    hmb_host_cpu_i.issue(HMB_WR_SOFT_RST, 16'h00f5);
    check_word("lengthOverflow", 18'h00001, {17'h00000, lengthOverflow});
    check_word("asyncBufferLength", 18'h00801, {2'b00, asyncBufferLength});
    check_word("hostSoftReset", 18'h00000, {17'h00000, hostSoftReset});
    rd(HMB_RD_SCRATCH, lfsr[15:0]);
    hmb_host_cpu_i.issue(HMB_WR_SOFT_RST, HMB_SOFT_RST_KEY);
    check_word("hostSoftReset", 18'h00001, {17'h00000, hostSoftReset});
    rd(HMB_RD_SCRATCH, 16'h0000);
    check_word("lengthOverflow", 18'h00000, {17'h00000, lengthOverflow});
    check_word("asyncBase", 18'h00000, {2'b00, asyncBase});
    rd(HMB_RD_PERIODIC, 16'h0000);
    rd(HMB_RD_ASYNC, 16'h0000);
    hmb_host_cpu_i.idle();
    repeat (3) @(negedge clk);
    check_word("pending reads", 18'h00000, 18'(expQ.size()));
    print_verdict();
  end
endmodule : host_misc_and_buffer_config_regs_test
`default_nettype wire
